// *** core/crvg_pkg.sv ***
package crvg_pkg;

  // ----------------------------------------------------------------
  // Register indices
  // ----------------------------------------------------------------
  localparam logic [4:0] IDX_VERT_TOTAL = 5'h06;
  localparam logic [4:0] IDX_OVERFLOW = 5'h07;
  localparam logic [4:0] IDX_PRESET_ROW = 5'h08;
  localparam logic [4:0] IDX_MAX_SCAN_LINE = 5'h09;
  localparam logic [4:0] IDX_CURSOR_START_ROW = 5'h0a;
  localparam logic [4:0] IDX_CURSOR_END_ROW = 5'h0b;
  localparam logic [4:0] IDX_DISPLAY_START_HIGH = 5'h0c;
  localparam logic [4:0] IDX_DISPLAY_START_LOW = 5'h0d;
  localparam logic [4:0] IDX_CURSOR_POSITION_HIGH = 5'h0e;
  localparam logic [4:0] IDX_CURSOR_POSITION_LOW = 5'h0f;
  localparam logic [4:0] IDX_VERT_SYNC_BEGIN = 5'h10;
  localparam logic [4:0] IDX_VERT_SYNC_FINISH_CTRL = 5'h11;
  localparam logic [4:0] IDX_VERT_ACTIVE_FINISH = 5'h12;
  localparam logic [4:0] IDX_ROW_PITCH = 5'h13;
  localparam logic [4:0] IDX_UNDERLINE_ROW = 5'h14;
  localparam logic [4:0] IDX_VERT_BLANK_BEGIN = 5'h15;
  localparam logic [4:0] IDX_VERT_BLANK_FINISH = 5'h16;
  localparam logic [4:0] IDX_TIMING_MODE_CONTROL = 5'h17;
  localparam logic [4:0] IDX_LAST_PROTECTED = 5'h07;
  localparam int NUM_REGS = 24;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int MSL_DOUBLE_BIT = 7;
  localparam int MSL_VBS9_BIT = 5;
  localparam int CUR_OFF_BIT = 5;
  localparam int OVF_VT8_BIT = 0;
  localparam int OVF_VDE8_BIT = 1;
  localparam int OVF_VRS8_BIT = 2;
  localparam int OVF_VBS8_BIT = 3;
  localparam int OVF_LC8_BIT = 4;
  localparam int OVF_VT9_BIT = 5;
  localparam int OVF_VDE9_BIT = 6;
  localparam int OVF_VRS9_BIT = 7;
  localparam int VSF_PROTECT_BIT = 7;
  localparam int VSF_REFRESH5_BIT = 6;
  localparam int VSF_INT_OFF_BIT = 5;
  localparam int VSF_INT_CLR_N_BIT = 4;
  localparam int UL_DWORD_BIT = 6;
  localparam int UL_COUNT4_BIT = 5;
  localparam int MC_TIMING_EN_BIT = 7;
  localparam int MC_BYTE_BIT = 6;
  localparam int MC_WRAP15_BIT = 5;
  localparam int MC_DIV2_BIT = 3;
  localparam int MC_VDIV_BIT = 2;
  localparam int MC_MA14_BIT = 1;
  localparam int MC_MA13_BIT = 0;

  // ----------------------------------------------------------------
  // Reset values and counts
  // ----------------------------------------------------------------
  localparam logic [7:0] REG_RESET = 8'h00;
  localparam logic [4:0] INDEX_RESET = 5'h00;
  localparam logic [2:0] REFRESH_LOW = 3'h3;
  localparam logic [2:0] REFRESH_HIGH = 3'h5;
  localparam logic [15:0] ROW_STEP_2X = 16'h0002;
  localparam logic [15:0] ROW_STEP_4X = 16'h0004;

  typedef struct packed {
    logic [15:0] addr;
    logic vretrace;
    logic vblank;
    logic vdisp;
    logic hretrace;
    logic cursor;
    logic underline;
  } crvg_disp_t;

endpackage

// *** core/crvg_timing.sv ***
`timescale 1ns/1ns
// Notes on behaviour
// - Line-doubling bit halves the row scan clock so each line shows twice.
// - Row scan advances each horizontal retrace, clears to zero at maximum.
// - Lines-per-row field is lines per row minus one, the maximum row scan; used as compare.
// - Cursor spans start to end row; off bit or start above end hides it.
// - Cursor delayed zero to three character clocks by the skew field.
// - Address counter loads 16-bit start address after vertical retrace.
// - Vertical retrace starts at a 10-bit line from start and overflow bits.
// - Protect bit blocks writes to registers 0-7 except line compare bit.
// - Three refresh cycles per line, five when refresh-count bit set.
// - Interrupt enabled when enable bit low; source shown in status bit.
// - Writing 0 to clear bit resets flag; software writes 1 back after.
// - Vertical retrace ends when line count low four bits match end field.
// - Display enable ends at 10-bit line using overflow bits 1 and 6.
// - Each new character row adds two or four times the row pitch.
// - Address counter steps per character clock, or divided by 2 or 4.
// - Underline on the row scan one above the programmed field.
// - Vertical blank starts one line above a 10-bit programmed value.
// - Vertical blank ends when line count matches 8-bit end value.
// - Timing-enable bit low holds both retraces cleared and keeps the retrace interrupt flag from setting.
// - Word mode shifts address up one, doubleword two, byte passes through.
// - Vertical-divide bit clocks the vertical counter at half line rate.
// - During display, row scan bits may replace address outputs 13 and 14.
// - Five-bit index written to address port selects the data port register.
// - Row scan loads the preset value after vertical retrace.
// - Overflow register holds bits 8 and 9 of the vertical values, except blank-start bit 9 (in the max scan line register).
module crvg_timing
  import crvg_pkg::*;
(
  input wire logic i_core_clk, // System clock
  input wire logic i_rstn, // Async reset, active low
  input wire logic i_index_wr, // Index port write strobe
  input wire logic i_data_wr, // Data port write strobe
  input wire logic [7:0] i_wdata, // Write data
  output logic [7:0] o_rdata, // Data port read value
  output logic [4:0] o_index, // Current index
  input wire logic i_char_tick, // Character clock pulse
  input wire logic i_hretrace, // Horizontal retrace from horizontal timing
  input wire logic i_hdisp, // Horizontal display enable
  output crvg_disp_t o_disp, // Display timing outputs
  output logic [8:0] o_refresh_row_addr, // Refresh address
  output logic o_refresh_cycle, // Refresh cycle pulse
  output logic o_irq, // Vertical retrace interrupt
  output logic o_vint_status // Interrupt source status bit
);

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  function automatic logic [9:0] join10(input logic b9, input logic b8, input logic [7:0] lo);
    join10 = {b9, b8, lo};
  endfunction

  function automatic logic [15:0] map_addr(input logic [15:0] c, input logic dword, input logic bytem,
                                           input logic wrap15);
    if (dword) begin
      map_addr = {c[13:0], c[13:12]};
    end else if (!bytem) begin
      map_addr = {c[14:0], wrap15 ? c[15] : c[13]};
    end else begin
      map_addr = c;
    end
  endfunction

  // ----------------------------------------------------------------
  // Register file
  // ----------------------------------------------------------------
  logic [7:0] regs_r [NUM_REGS];
  logic [7:0] regs_nxt [NUM_REGS];
  logic [4:0] index_r, index_nxt;
  logic [7:0] rdata_r, rdata_nxt;

  always_comb begin
    for (int i = 0; i < NUM_REGS; i++) begin
      regs_nxt[i] = regs_r[i];
    end
    index_nxt = index_r;
    if (i_index_wr) begin
      index_nxt = i_wdata[4:0];
    end
    if (i_data_wr && (index_r < 5'(NUM_REGS))) begin
      if (regs_r[IDX_VERT_SYNC_FINISH_CTRL][VSF_PROTECT_BIT] && (index_r <= IDX_LAST_PROTECTED)) begin
        if (index_r == IDX_OVERFLOW) begin
          regs_nxt[IDX_OVERFLOW][OVF_LC8_BIT] = i_wdata[OVF_LC8_BIT];
        end
      end else begin
        regs_nxt[index_r] = i_wdata;
      end
    end
    rdata_nxt = (index_nxt < 5'(NUM_REGS)) ? regs_nxt[index_nxt] : REG_RESET;
  end

  always_ff @(posedge i_core_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      for (int i = 0; i < NUM_REGS; i++) begin
        regs_r[i] <= REG_RESET;
      end
      index_r <= INDEX_RESET;
      rdata_r <= REG_RESET;
    end else begin
      regs_r <= regs_nxt;
      index_r <= index_nxt;
      rdata_r <= rdata_nxt;
    end
  end

  assign o_rdata = rdata_r;
  assign o_index = index_r;

  // ----------------------------------------------------------------
  // Decoded fields
  // ----------------------------------------------------------------
  logic [7:0] ovf, msl, ctl, ul, vsf;
  logic [9:0] vtotal, vrs, vde, vbs;
  logic timing_en, dword, count4;

  assign ovf = regs_r[IDX_OVERFLOW];
  assign msl = regs_r[IDX_MAX_SCAN_LINE];
  assign ctl = regs_r[IDX_TIMING_MODE_CONTROL];
  assign ul = regs_r[IDX_UNDERLINE_ROW];
  assign vsf = regs_r[IDX_VERT_SYNC_FINISH_CTRL];
  assign vtotal = join10(ovf[OVF_VT9_BIT], ovf[OVF_VT8_BIT], regs_r[IDX_VERT_TOTAL]);
  assign vrs = join10(ovf[OVF_VRS9_BIT], ovf[OVF_VRS8_BIT], regs_r[IDX_VERT_SYNC_BEGIN]);
  assign vde = join10(ovf[OVF_VDE9_BIT], ovf[OVF_VDE8_BIT], regs_r[IDX_VERT_ACTIVE_FINISH]);
  assign vbs = join10(msl[MSL_VBS9_BIT], ovf[OVF_VBS8_BIT], regs_r[IDX_VERT_BLANK_BEGIN]);
  assign timing_en = ctl[MC_TIMING_EN_BIT];
  assign dword = ul[UL_DWORD_BIT];
  assign count4 = ul[UL_COUNT4_BIT];

  // ----------------------------------------------------------------
  // Vertical timing and row scan
  // ----------------------------------------------------------------
  logic hret_d_r, vdiv_r, vdiv_nxt, dbl_r, dbl_nxt;
  logic [9:0] vcnt_r, vcnt_nxt;
  logic [4:0] row_r, row_nxt;
  logic vret_r, vret_nxt, vblank_r, vblank_nxt;
  logic [15:0] row_start_r, row_start_nxt;
  logic line_edge, vline, row_tick, frame_end, vret_begin;

  assign line_edge = i_hretrace && !hret_d_r;
  assign vline = line_edge && (!ctl[MC_VDIV_BIT] || vdiv_r);
  assign row_tick = vline && (!msl[MSL_DOUBLE_BIT] || dbl_r);
  assign frame_end = vline && (vcnt_r == vtotal + 10'h001);
  assign vret_begin = vline && (vcnt_nxt == vrs) && timing_en;

  always_comb begin
    vdiv_nxt = vdiv_r;
    dbl_nxt = dbl_r;
    vcnt_nxt = vcnt_r;
    row_nxt = row_r;
    row_start_nxt = row_start_r;
    vret_nxt = vret_r;
    vblank_nxt = vblank_r;
    if (line_edge) begin
      vdiv_nxt = !vdiv_r;
    end
    if (vline) begin
      dbl_nxt = !dbl_r;
      vcnt_nxt = frame_end ? 10'h000 : vcnt_r + 10'h001;
    end
    if (frame_end) begin
      row_nxt = regs_r[IDX_PRESET_ROW][4:0];
      row_start_nxt = {regs_r[IDX_DISPLAY_START_HIGH], regs_r[IDX_DISPLAY_START_LOW]};
      dbl_nxt = 1'b0;
    end else if (row_tick) begin
      if (row_r == msl[4:0]) begin
        row_nxt = 5'h00;
        // Row start steps by two or four times the pitch
        row_start_nxt = row_start_r + ((count4 || dword) ? ROW_STEP_4X : ROW_STEP_2X) *
                        {8'h00, regs_r[IDX_ROW_PITCH]};
      end else begin
        row_nxt = row_r + 5'h01;
      end
    end
    if (vline) begin
      if (vcnt_nxt == vrs) begin
        vret_nxt = 1'b1;
      end else if (vcnt_nxt[3:0] == vsf[3:0]) begin
        vret_nxt = 1'b0;
      end
      if (vcnt_nxt == vbs + 10'h001) begin
        vblank_nxt = 1'b1;
      end else if (vcnt_nxt[7:0] == regs_r[IDX_VERT_BLANK_FINISH]) begin
        vblank_nxt = 1'b0;
      end
    end
    if (!timing_en) begin
      vret_nxt = 1'b0;
    end
  end

  always_ff @(posedge i_core_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      hret_d_r <= 1'b0;
      vdiv_r <= 1'b0;
      dbl_r <= 1'b0;
      vcnt_r <= 10'h000;
      row_r <= 5'h00;
      row_start_r <= 16'h0000;
      vret_r <= 1'b0;
      vblank_r <= 1'b0;
    end else begin
      hret_d_r <= i_hretrace;
      vdiv_r <= vdiv_nxt;
      dbl_r <= dbl_nxt;
      vcnt_r <= vcnt_nxt;
      row_r <= row_nxt;
      row_start_r <= row_start_nxt;
      vret_r <= vret_nxt;
      vblank_r <= vblank_nxt;
    end
  end

  // ----------------------------------------------------------------
  // Address counter and refresh
  // ----------------------------------------------------------------
  logic [15:0] ma_r, ma_nxt;
  logic [1:0] pre_r, pre_nxt;
  logic [2:0] rcnt_r, rcnt_nxt;
  logic [8:0] rfa_r, rfa_nxt;
  logic rcyc_r, rcyc_nxt;
  logic ma_step, vdisp;

  assign vdisp = (vcnt_r <= vde);
  assign ma_step = i_char_tick && i_hdisp &&
                   (count4 ? (pre_r == 2'h3) : (ctl[MC_DIV2_BIT] ? pre_r[0] : 1'b1));

  always_comb begin
    ma_nxt = ma_r;
    pre_nxt = pre_r;
    rcnt_nxt = rcnt_r;
    rfa_nxt = rfa_r;
    rcyc_nxt = 1'b0;
    if (line_edge) begin
      ma_nxt = row_start_nxt;
      pre_nxt = 2'h0;
      // Refresh burst length taken at each line start
      rcnt_nxt = vsf[VSF_REFRESH5_BIT] ? REFRESH_HIGH : REFRESH_LOW;
    end else begin
      if (i_char_tick && i_hdisp) begin
        pre_nxt = pre_r + 2'h1;
      end
      if (ma_step) begin
        ma_nxt = ma_r + 16'h0001;
      end
      if (i_char_tick && i_hretrace && (rcnt_r != 3'h0)) begin
        rcnt_nxt = rcnt_r - 3'h1;
        rfa_nxt = rfa_r + 9'h001;
        rcyc_nxt = 1'b1;
      end
    end
  end

  always_ff @(posedge i_core_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      ma_r <= 16'h0000;
      pre_r <= 2'h0;
      rcnt_r <= 3'h0;
      rfa_r <= 9'h000;
      rcyc_r <= 1'b0;
    end else begin
      ma_r <= ma_nxt;
      pre_r <= pre_nxt;
      rcnt_r <= rcnt_nxt;
      rfa_r <= rfa_nxt;
      rcyc_r <= rcyc_nxt;
    end
  end

  assign o_refresh_row_addr = rfa_r;
  assign o_refresh_cycle = rcyc_r;

  // ----------------------------------------------------------------
  // Cursor, underline, interrupt and outputs
  // ----------------------------------------------------------------
  logic [2:0] skew_r, skew_nxt;
  logic vint_r, vint_nxt;
  crvg_disp_t disp_r, disp_nxt;
  logic [4:0] cur_start, cur_end;
  logic cur_raw, active;
  logic [15:0] addr_mapped;

  assign cur_start = regs_r[IDX_CURSOR_START_ROW][4:0];
  assign cur_end = regs_r[IDX_CURSOR_END_ROW][4:0];
  assign active = i_hdisp && vdisp;
  assign cur_raw = active && !regs_r[IDX_CURSOR_START_ROW][CUR_OFF_BIT] && (cur_start <= cur_end) &&
                   (row_r >= cur_start) && (row_r <= cur_end) &&
                   (ma_r == {regs_r[IDX_CURSOR_POSITION_HIGH], regs_r[IDX_CURSOR_POSITION_LOW]});
  assign addr_mapped = map_addr(ma_r, dword, ctl[MC_BYTE_BIT], ctl[MC_WRAP15_BIT]);

  always_comb begin
    skew_nxt = skew_r;
    if (i_char_tick) begin
      skew_nxt = {skew_r[1:0], cur_raw};
    end
    // Clear bit held low wins over a new retrace start
    vint_nxt = vint_r;
    if (!vsf[VSF_INT_CLR_N_BIT]) begin
      vint_nxt = 1'b0;
    end else if (vret_begin && !vsf[VSF_INT_OFF_BIT]) begin
      vint_nxt = 1'b1;
    end
    disp_nxt.addr = addr_mapped;
    if (active && !ctl[MC_MA13_BIT]) begin
      disp_nxt.addr[13] = row_r[0];
    end
    if (active && !ctl[MC_MA14_BIT]) begin
      disp_nxt.addr[14] = row_r[1];
    end
    unique case (regs_r[IDX_CURSOR_END_ROW][6:5])
      2'h0: disp_nxt.cursor = cur_raw;
      2'h1: disp_nxt.cursor = skew_r[0];
      2'h2: disp_nxt.cursor = skew_r[1];
      2'h3: disp_nxt.cursor = skew_r[2];
    endcase
    disp_nxt.underline = active && (row_r == ul[4:0] + 5'h01);
    disp_nxt.vretrace = vret_nxt;
    disp_nxt.vblank = vblank_nxt;
    disp_nxt.vdisp = vdisp;
    disp_nxt.hretrace = i_hretrace && timing_en;
  end

  always_ff @(posedge i_core_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      skew_r <= 3'h0;
      vint_r <= 1'b0;
      disp_r <= '0;
    end else begin
      skew_r <= skew_nxt;
      vint_r <= vint_nxt;
      disp_r <= disp_nxt;
    end
  end

  assign o_disp = disp_r;
  assign o_vint_status = vint_r;
  assign o_irq = vint_r && !vsf[VSF_INT_OFF_BIT];

endmodule

// *** bench/crvg_timing_assertions.sv ***
`timescale 1ns/1ns
module crvg_timing_checker
  import crvg_pkg::*;
(
  input wire logic i_core_clk, // Clock
  input wire logic i_rstn, // Reset, active low
  input wire logic i_index_wr, // Index strobe
  input wire logic i_data_wr, // Data strobe
  input wire logic [7:0] i_wdata, // Write data
  input wire logic [7:0] o_rdata, // Read data
  input wire logic [4:0] o_index, // Index
  input wire logic i_char_tick, // Char tick
  input wire logic i_hretrace, // Line retrace
  input wire logic i_hdisp, // Line display
  input wire crvg_disp_t o_disp, // Display outputs
  input wire logic [8:0] o_refresh_row_addr, // Refresh address
  input wire logic o_refresh_cycle, // Refresh pulse
  input wire logic o_irq, // Interrupt
  input wire logic o_vint_status // Flag
);
  // -----
  // Shadows and refresh count
  // -----
  logic [7:0] sh11_r, sh11_nxt, sh17_r, sh17_nxt;
  logic [2:0] rf_r, rf_nxt;
  logic hr_d_r, lim_r, lim_nxt, line_start;
  always_comb begin
    sh11_nxt = sh11_r;
    sh17_nxt = sh17_r;
    if (i_data_wr && o_index == IDX_VERT_SYNC_FINISH_CTRL) sh11_nxt = i_wdata;
    if (i_data_wr && o_index == IDX_TIMING_MODE_CONTROL) sh17_nxt = i_wdata;
    line_start = i_hretrace && !hr_d_r;
    rf_nxt = line_start ? 3'h0 : rf_r + {2'h0, o_refresh_cycle};
    lim_nxt = line_start ? sh11_r[VSF_REFRESH5_BIT] : (lim_r | sh11_r[VSF_REFRESH5_BIT]);
  end
  always_ff @(posedge i_core_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      sh11_r <= 8'h00;
      sh17_r <= 8'h00;
      rf_r <= 3'h0;
      lim_r <= 1'b0;
      hr_d_r <= 1'b0;
    end else begin
      sh11_r <= sh11_nxt;
      sh17_r <= sh17_nxt;
      rf_r <= rf_nxt;
      lim_r <= lim_nxt;
      hr_d_r <= i_hretrace;
    end
  end
  default clocking cb @(posedge i_core_clk); endclocking
  default disable iff (!i_rstn);
  chk_index_load: assert property (i_index_wr |=> o_index == $past(i_wdata[4:0]))
    else $error("index not loaded");
  chk_unmapped_zero: assert property (o_index >= 5'h18 && $stable(o_index) |-> o_rdata == 8'h00)
    else $error("unmapped index reads nonzero");
  chk_start_echo: assert property (i_data_wr && !i_index_wr && (o_index == IDX_DISPLAY_START_HIGH ||
    o_index == IDX_DISPLAY_START_LOW) |=> o_rdata == $past(i_wdata)) else $error("start address not stored");
  chk_protect_hold: assert property (i_data_wr && !i_index_wr && sh11_r[VSF_PROTECT_BIT] &&
    o_index == IDX_VERT_TOTAL |=> o_rdata == $past(o_rdata))
    else $error("protected register changed");
  chk_irq_gate: assert property (o_irq |-> o_vint_status && !(sh11_r[5] && $past(sh11_r[5])))
    else $error("interrupt without enabled flag");
  chk_clear_held: assert property (!sh11_r[VSF_INT_CLR_N_BIT] |=> !o_vint_status)
    else $error("flag set while clear bit low");
  chk_flag_source: assert property ($rose(o_vint_status) && sh17_r[7] |-> ##[0:2] o_disp.vretrace)
    else $error("flag set outside retrace");
  chk_timing_off: assert property (!sh17_r[7] && !$past(sh17_r[7]) && !$past(sh17_r[7], 2)
    |-> !o_disp.vretrace) else $error("retrace while timing disabled");
  chk_refresh_max: assert property (rf_r <= (lim_r ? 3'h5 : 3'h3))
    else $error("too many refresh cycles in a line");
  cov_irq: cover property ($rose(o_vint_status));
  cov_five: cover property (rf_r == 3'h5);
  cov_vret: cover property ($rose(o_disp.vretrace));
  cov_underline: cover property ($rose(o_disp.underline));
endmodule
bind crvg_timing crvg_timing_checker crvg_timing_checker_inst (.i_core_clk, .i_rstn, .i_index_wr,
  .i_data_wr, .i_wdata, .o_rdata, .o_index, .i_char_tick, .i_hretrace, .i_hdisp, .o_disp,
  .o_refresh_row_addr, .o_refresh_cycle, .o_irq, .o_vint_status);

// *** bench/crvg_crt_model.sv ***
`timescale 1ns/1ns
module crvg_crt_model (
  input wire logic i_core_clk, // Clock
  input wire logic i_rstn, // Reset, active low
  input wire logic i_slow, // Tick every 4 clocks, else 2
  output logic o_char_tick, // Character tick
  output logic o_hretrace, // Line retrace level
  output logic o_hdisp // Line display level
);
  // -----
  // 20-character line, retrace on 14..19
  // -----
  logic [1:0] div_r, div_nxt;
  logic [4:0] chr_r, chr_nxt;
  logic tick_nxt, hr_nxt, hd_nxt;
  always_comb begin
    tick_nxt = (div_r == {i_slow, 1'b1});
    div_nxt = tick_nxt ? 2'h0 : div_r + 2'h1;
    chr_nxt = chr_r;
    if (o_char_tick) chr_nxt = (chr_r == 5'h13) ? 5'h00 : chr_r + 5'h01;
    // Levels follow the new count so they never change on a tick
    hr_nxt = chr_nxt >= 5'h0e;
    hd_nxt = chr_nxt < 5'h0c;
  end
  always_ff @(posedge i_core_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      div_r <= 2'h0;
      chr_r <= 5'h00;
      o_char_tick <= 1'b0;
      o_hretrace <= 1'b0;
      o_hdisp <= 1'b0;
    end else begin
      div_r <= div_nxt;
      chr_r <= chr_nxt;
      o_char_tick <= tick_nxt;
      o_hretrace <= hr_nxt;
      o_hdisp <= hd_nxt;
    end
  end
endmodule

// *** bench/crvg_timing_tb_top.sv ***
`timescale 1ns/1ns
module crvg_timing_tb_top
  import crvg_pkg::*;
;
  logic i_core_clk, i_rstn, i_index_wr, i_data_wr, slow, tick, hret, hdisp;
  logic o_refresh_cycle, o_irq, o_vint_status;
  logic [7:0] i_wdata, o_rdata, v, pitch;
  logic [15:0] st;
  logic [4:0] o_index;
  logic [8:0] o_refresh_row_addr;
  logic [8:0] ra;
  logic [15:0] cfg [12] = '{16'h111c, 16'h0700, 16'h0800, 16'h0901, 16'h100a, 16'h1208,
    16'h150b, 16'h160e, 16'h1400, 16'h0a20, 16'h0b00, 16'h17c3};
  crvg_disp_t o_disp;
  integer seed = 98, bad_count = 0, samples_checked = 0, i, n;
  crvg_timing crvg_timing_inst (.i_core_clk, .i_rstn, .i_index_wr, .i_data_wr, .i_wdata, .o_rdata,
    .o_index, .i_char_tick(tick), .i_hretrace(hret), .i_hdisp(hdisp), .o_disp, .o_refresh_row_addr,
    .o_refresh_cycle, .o_irq, .o_vint_status);
  crvg_crt_model crvg_crt_model_inst (.i_core_clk, .i_rstn, .i_slow(slow), .o_char_tick(tick),
    .o_hretrace(hret), .o_hdisp(hdisp));
  initial begin
    i_core_clk = 1'b0;
    forever #5 i_core_clk = ~i_core_clk;
  end
  // -----
  // Helpers
  // -----
  task wrap_up;
    $display("checks %0d mismatches %0d", samples_checked, bad_count);
    if (bad_count == 0 && samples_checked > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  task check(input logic [15:0] got, input logic [15:0] exp, input string what);
    samples_checked++;
    if (got !== exp) begin
      bad_count++;
      $display("[ERR] %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask
  task step(input int k);
    repeat (k) @(posedge i_core_clk);
    #1;
  endtask
  task wr(input logic [4:0] idx, input logic [7:0] d);
    i_index_wr = 1'b1;
    i_wdata = {3'h0, idx};
    step(1);
    i_index_wr = 1'b0;
    i_data_wr = 1'b1;
    i_wdata = d;
    step(1);
    i_data_wr = 1'b0;
  endtask
  task rd(input logic [4:0] idx, input logic [7:0] exp, input logic [7:0] m);
    i_index_wr = 1'b1;
    i_wdata = {3'h0, idx};
    step(1);
    i_index_wr = 1'b0;
    step(2);
    check({8'h00, o_rdata & m}, {8'h00, exp & m}, "register read");
    check({11'h000, o_index}, {11'h000, idx}, "index readback");
  endtask
  function automatic logic [7:0] mask(input logic [4:0] idx);
    case (idx)
      5'h0a: mask = 8'h3f;
      5'h0b, 5'h14: mask = 8'h7f;
      5'h17: mask = 8'hef;
      default: mask = 8'hff;
    endcase
  endfunction
  function automatic logic sel(input int w);
    case (w)
      0: sel = hdisp;
      1: sel = o_disp.vdisp;
      2: sel = o_vint_status;
      default: sel = hret;
    endcase
  endfunction
  task wait_on(input int w, input logic want);
    int k;
    k = 0;
    while (sel(w) !== want && k < 5000) begin
      step(1);
      k++;
    end
    if (k == 5000) begin
      bad_count++;
      $display("[ERR] %0t wait timed out", $time);
    end
  endtask
  task next_line;
    wait_on(0, 1'b0);
    wait_on(0, 1'b1);
    step(1);
  endtask
  initial begin
    #900000;
    bad_count++;
    wrap_up;
  end
  // -----
  // Tests
  // -----
  initial begin
    i_rstn = 1'b0;
    i_index_wr = 1'b0;
    i_data_wr = 1'b0;
    i_wdata = 8'h00;
    slow = 1'b0;
    repeat (20) @(posedge i_core_clk);
    #1 i_rstn = 1'b1;
    step(1);
    for (i = 9; i < 24; i++) begin
      v = 8'($random(seed));
      if (i == 17) v = v & 8'h6f;
      wr(i[4:0], v);
      rd(i[4:0], v, mask(i[4:0]));
    end
    rd(5'h18, 8'h00, 8'hff);
    wr(5'h1f, 8'h5a);
    rd(5'h1f, 8'h00, 8'hff);
    $display("test registers done");
    wr(IDX_VERT_TOTAL, 8'h0f);
    wr(IDX_OVERFLOW, 8'h00);
    wr(IDX_VERT_SYNC_FINISH_CTRL, 8'h90);
    wr(IDX_VERT_TOTAL, 8'h33);
    rd(IDX_VERT_TOTAL, 8'h0f, 8'hff);
    wr(IDX_OVERFLOW, 8'hff);
    rd(IDX_OVERFLOW, 8'h10, 8'hff);
    $display("test protect done");
    pitch = 8'($random(seed));
    st = 16'($random(seed));
    for (i = 0; i < 12; i++) wr(cfg[i][12:8], cfg[i][7:0]);
    wr(IDX_ROW_PITCH, pitch);
    wr(IDX_DISPLAY_START_HIGH, st[15:8]);
    wr(IDX_DISPLAY_START_LOW, st[7:0]);
    wait_on(1, 1'b0);
    wait_on(1, 1'b1);
    wait_on(0, 1'b1);
    step(1);
    check(o_disp.addr, st, "frame start address");
    check({15'h0000, o_disp.underline}, 16'h0000, "no underline on row 0");
    next_line;
    check(o_disp.addr, st, "second line of row");
    check({15'h0000, o_disp.underline}, 16'h0001, "underline on row 1");
    next_line;
    check(o_disp.addr, st + {7'h00, pitch, 1'b0}, "next row address");
    $display("test addressing done");
    wr(IDX_VERT_SYNC_FINISH_CTRL, 8'h0c);
    step(1);
    check({15'h0000, o_vint_status}, 16'h0000, "flag after clear");
    wait_on(1, 1'b0);
    wait_on(1, 1'b1);
    check({15'h0000, o_vint_status}, 16'h0000, "flag held while clear bit low");
    wr(IDX_VERT_SYNC_FINISH_CTRL, 8'h1c);
    wait_on(2, 1'b1);
    check({15'h0000, o_irq}, 16'h0001, "interrupt enabled");
    wr(IDX_VERT_SYNC_FINISH_CTRL, 8'h0c);
    wr(IDX_VERT_SYNC_FINISH_CTRL, 8'h3c);
    wait_on(1, 1'b1);
    wait_on(1, 1'b0);
    wait_on(1, 1'b1);
    check({15'h0000, o_vint_status}, 16'h0000, "flag while interrupt disabled");
    check({15'h0000, o_irq}, 16'h0000, "interrupt disabled");
    $display("test interrupt done");
    for (i = 0; i < 4; i++) begin
      wr(IDX_VERT_SYNC_FINISH_CTRL, i[0] ? 8'h5c : 8'h1c);
      slow = 1'($random(seed));
      wait_on(3, 1'b0);
      wait_on(3, 1'b1);
      n = 0;
      ra = o_refresh_row_addr;
      do begin
        step(1);
        n += (o_refresh_cycle === 1'b1);
      end while (hret !== 1'b0);
      check(n[15:0], i[0] ? 16'h0005 : 16'h0003, "refresh cycles per line");
      check({7'h00, o_refresh_row_addr - ra}, i[0] ? 16'h0005 : 16'h0003, "refresh address advance");
    end
    $display("test refresh done");
    wrap_up;
  end
endmodule
